// >>> include/scd_pkg.sv
package scd_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int DATA_W    = 16;
	localparam int PC_W      = 16;
	localparam int MEM_AW    = 12;
	localparam int INSTR_W   = 8;
	localparam int REG_COUNT = 16;
	localparam int SEL_W     = 4;

	// ------------------------------------------------------------
	// Instruction fields
	// ------------------------------------------------------------
	localparam int OP_HI  = 7;
	localparam int OP_LO  = 4;
	localparam int SEL_HI = 3;
	localparam int SEL_LO = 0;

	// ------------------------------------------------------------
	// Reset values and counts
	// ------------------------------------------------------------
	localparam logic [PC_W-1:0]   PC_RESET    = 16'h0000;
	localparam logic [PC_W-1:0]   PC_STEP     = 16'h0001;
	localparam logic [DATA_W-1:0] REG_RESET   = 16'h0000;
	localparam logic [DATA_W-1:0] CLEAR_VALUE = 16'h0000;
	localparam int                LOAD_CYCLES = 3;

	// ------------------------------------------------------------
	// Special registers
	// ------------------------------------------------------------
	localparam logic [SEL_W-1:0] SHIFT_FILL_REG  = 4'h6;
	localparam logic [SEL_W-1:0] SHIFT_SRC_REG   = 4'h4;
	localparam logic [SEL_W-1:0] ACC_REG_DEFAULT = 4'ha;

	// ------------------------------------------------------------
	// Opcodes handled here
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		load_immediate_op = 4'h0,
		clear_reg_op      = 4'h1,
		and_accum_op      = 4'h2,
		or_accum_op       = 4'h3,
		add_accum_op      = 4'h4,
		store_accum_op    = 4'h5,
		shift_left_op     = 4'h6
	} scd_op_e;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_EXEC    = 2'b00,
		ST_LOAD_HI = 2'b01,
		ST_LOAD_LO = 2'b10
	} scd_state_e;

endpackage

// >>> include/scd_rf_if.sv
`timescale 1ns/1ps
interface scd_rf_if;
	import scd_pkg::*;

	logic [SEL_W-1:0]  rdSel;
	logic [DATA_W-1:0] rdData;
	logic [DATA_W-1:0] accData;
	logic              srcMsb;
	logic              wrEn;
	logic [SEL_W-1:0]  wrSel;
	logic [DATA_W-1:0] wrData;
	logic [SEL_W-1:0]  dbgSel;
	logic [DATA_W-1:0] dbgData;

	// Core side drives selects and the write port
	modport core (
		output rdSel,
		output wrEn,
		output wrSel,
		output wrData,
		output dbgSel,
		input  rdData,
		input  accData,
		input  srcMsb,
		input  dbgData
	);

	// Register array side
	modport regs (
		input  rdSel,
		input  wrEn,
		input  wrSel,
		input  wrData,
		input  dbgSel,
		output rdData,
		output accData,
		output srcMsb,
		output dbgData
	);

endinterface

// >>> rtl/scd_regfile.sv
`timescale 1ns/1ps
module scd_regfile
	import scd_pkg::*;
#(
	parameter logic [SEL_W-1:0] ACC_IDX = ACC_REG_DEFAULT
) (
	input  wire logic ref_clk,
	input  wire logic rst_n,
	scd_rf_if.regs    rf
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [DATA_W-1:0] regsQ [REG_COUNT];
	logic [DATA_W-1:0] dbgQ;

	// Single write port, only the named register changes
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < REG_COUNT; i++) begin
				regsQ[i] <= REG_RESET;
			end
		end else if (rf.wrEn) begin
			regsQ[rf.wrSel] <= rf.wrData;
		end
	end

	// Registered observation port
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			dbgQ <= REG_RESET;
		end else begin
			dbgQ <= regsQ[rf.dbgSel];
		end
	end

	// ------------------------------------------------------------
	// Read ports
	// ------------------------------------------------------------
	assign rf.rdData  = regsQ[rf.rdSel];
	assign rf.accData = regsQ[ACC_IDX];
	assign rf.srcMsb  = regsQ[SHIFT_SRC_REG][DATA_W-1];
	assign rf.dbgData = dbgQ;

endmodule

// >>> rtl/scd_core.sv
`timescale 1ns/1ps
// Summary of operation
// - after reset fetch starts at 0000h and steps one byte at a time
// - program counter is 16 bits, only low 12 bits reach memory
// - instruction bits 7-4 are the opcode, bits 3-0 the register selector
// - selector reaches all sixteen 16-bit registers; the accumulator operand is fixed at ACC_IDX
// - all operations take one byte except load-immediate, which takes three
// - load-immediate reads upper then lower byte, writes both in one write in its third cycle, PC plus three, three cycles
// - clear writes zero to selected register only
// - AND of accumulator and selected register goes to accumulator
// - OR of accumulator and selected register goes to accumulator
// - add selected register to accumulator, low sixteen bits kept
// - store copies accumulator into selected register, accumulator unchanged
// - opcode 6 is a one-cycle left shift, special fill for register six
// - single-byte operations take one cycle and add one to PC
// - no branch, no register changes except destination and PC
// - shift drops bit 15, fills zero, or register four top bit for six
// - core only reads program memory, never erases or writes flash
module scd_core
	import scd_pkg::*;
#(
	parameter logic [SEL_W-1:0] ACC_IDX = ACC_REG_DEFAULT
) (
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	input  wire logic                haltReq,
	input  wire logic [INSTR_W-1:0]  progData,
	output logic      [MEM_AW-1:0]   progAddr,
	output logic                     progRdEn,
	output logic                     haltAck,
	output logic                     foreignOp,
	output logic      [INSTR_W-1:0]  foreignInstr,
	input  wire logic [SEL_W-1:0]    dbgSel,
	output logic      [DATA_W-1:0]   dbgData
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	// Refuse sizes that the address cut or the selector cannot serve
	if (MEM_AW > PC_W) begin : gBadAddrW
		$error("Memory address wider than program counter");
	end
	if (REG_COUNT != (1 << SEL_W)) begin : gBadRegCount
		$error("Selector does not cover the register set");
	end

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	function automatic logic [3:0] opField(input logic [INSTR_W-1:0] instr);
		return instr[OP_HI:OP_LO];
	endfunction

	function automatic logic [SEL_W-1:0] selField(input logic [INSTR_W-1:0] instr);
		return instr[SEL_HI:SEL_LO];
	endfunction

	function automatic logic [DATA_W-1:0] shiftLeft(
		input logic [DATA_W-1:0] val,
		input logic [SEL_W-1:0]  sel,
		input logic              srcMsb
	);
		logic fill;
		fill = (sel == SHIFT_FILL_REG) ? srcMsb : 1'b0;
		return {val[DATA_W-2:0], fill};
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	scd_rf_if rf ();

	scd_state_e        stateQ;
	scd_state_e        stateD;
	logic [PC_W-1:0]   pcQ;
	logic [SEL_W-1:0]  loadSelQ;
	logic [7:0]        loadHiQ;
	logic              run;
	logic [3:0]        op;
	logic [SEL_W-1:0]  sel;
	logic              isExec;
	logic              foreignD;

	assign run    = !haltReq;
	assign op     = opField(progData);
	assign sel    = selField(progData);
	assign isExec = (stateQ == ST_EXEC);

	scd_regfile #(
		.ACC_IDX (ACC_IDX)
	) u_regs (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.rf      (rf.regs)
	);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------

	// Next state, load-immediate spans three cycles
	always_comb begin
		stateD = stateQ;
		unique case (stateQ)
			ST_EXEC: begin
				if (run && op == load_immediate_op) begin
					stateD = ST_LOAD_HI;
				end
			end
			ST_LOAD_HI: begin
				if (run) begin
					stateD = ST_LOAD_LO;
				end
			end
			ST_LOAD_LO: begin
				if (run) begin
					stateD = ST_EXEC;
				end
			end
			default: begin
				stateD = ST_EXEC;
			end
		endcase
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			stateQ <= ST_EXEC;
		end else begin
			stateQ <= stateD;
		end
	end

	// Program counter, one byte per cycle, no branches here
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			pcQ <= PC_RESET;
		end else if (run) begin
			pcQ <= pcQ + PC_STEP;
		end
	end

	// Load-immediate destination and upper byte
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			loadSelQ <= '0;
			loadHiQ  <= '0;
		end else if (run) begin
			if (isExec && op == load_immediate_op) begin
				loadSelQ <= sel;
			end
			if (stateQ == ST_LOAD_HI) begin
				loadHiQ <= progData;
			end
		end
	end

	// ------------------------------------------------------------
	// Memory side, read only
	// ------------------------------------------------------------
	assign progAddr = pcQ[MEM_AW-1:0];
	assign progRdEn = run;

	// ------------------------------------------------------------
	// Execute
	// ------------------------------------------------------------

	// Operand select and single write port
	always_comb begin
		rf.rdSel  = sel;
		rf.wrEn   = 1'b0;
		rf.wrSel  = sel;
		rf.wrData = rf.rdData;
		foreignD  = 1'b0;
		if (run && stateQ == ST_LOAD_LO) begin
			rf.wrEn   = 1'b1;
			rf.wrSel  = loadSelQ;
			rf.wrData = {loadHiQ, progData};
		end else if (run && isExec) begin
			unique case (op)
				load_immediate_op: begin
					rf.wrEn = 1'b0;
				end
				clear_reg_op: begin
					rf.wrEn   = 1'b1;
					rf.wrData = CLEAR_VALUE;
				end
				and_accum_op: begin
					rf.wrEn   = 1'b1;
					rf.wrSel  = ACC_IDX;
					rf.wrData = rf.accData & rf.rdData;
				end
				or_accum_op: begin
					rf.wrEn   = 1'b1;
					rf.wrSel  = ACC_IDX;
					rf.wrData = rf.accData | rf.rdData;
				end
				add_accum_op: begin
					rf.wrEn   = 1'b1;
					rf.wrSel  = ACC_IDX;
					rf.wrData = DATA_W'(rf.accData + rf.rdData);
				end
				store_accum_op: begin
					rf.wrEn   = 1'b1;
					rf.wrData = rf.accData;
				end
				shift_left_op: begin
					rf.wrEn   = 1'b1;
					rf.wrData = shiftLeft(rf.rdData, sel, rf.srcMsb);
				end
				default: begin
					foreignD = 1'b1;
				end
			endcase
		end
	end

	// Hand-off of opcodes served by other logic
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			foreignOp    <= 1'b0;
			foreignInstr <= '0;
		end else begin
			foreignOp <= foreignD;
			if (foreignD) begin
				foreignInstr <= progData;
			end
		end
	end

	// Halt acknowledge
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			haltAck <= 1'b0;
		end else begin
			haltAck <= haltReq;
		end
	end

	assign rf.dbgSel = dbgSel;
	assign dbgData   = rf.dbgData;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	logic [SEL_W-1:0] selPrev;
	always_ff @(posedge ref_clk) begin
		selPrev <= sel;
	end

	sequence execOp(logic [3:0] code);
		run && isExec && op == code;
	endsequence

	sequence loadTail;
		(run && stateQ == ST_LOAD_HI) ##1 (run && stateQ == ST_LOAD_LO);
	endsequence

	a_pc_reset: assert property (disable iff (1'b0)
		!rst_n |=> pcQ == PC_RESET)
		else $error("PC not zero after reset");

	a_single_step: assert property (
		(run && isExec && op != load_immediate_op) |=>
			(pcQ == $past(pcQ) + PC_STEP) && isExec)
		else $error("Single-byte op did not step PC by one");

	a_load_three: assert property (
		execOp(load_immediate_op) ##1 loadTail |=>
			isExec && pcQ == $past(pcQ, 3) + PC_W'(LOAD_CYCLES))
		else $error("Load did not take three cycles");

	a_load_write: assert property (
		(run && stateQ == ST_LOAD_LO) |->
			rf.wrEn && rf.wrSel == loadSelQ && rf.wrData[7:0] == progData
			&& rf.wrData[15:8] == loadHiQ)
		else $error("Load wrote wrong bytes");

	// Upper byte read in ST_LOAD_HI is latched at the edge ending that cycle and held in the next
	a_load_upper: assert property (
		(run && stateQ == ST_LOAD_HI) |=> loadHiQ == $past(progData))
		else $error("Load upper byte not kept");

	a_clear_zero: assert property (
		execOp(clear_reg_op) |=> u_regs.regsQ[selPrev] == CLEAR_VALUE)
		else $error("Clear did not zero register");

	a_and_acc: assert property (
		execOp(and_accum_op) |=>
			rf.accData == ($past(rf.accData) & $past(rf.rdData)))
		else $error("AND result wrong");

	a_or_acc: assert property (
		execOp(or_accum_op) |=>
			rf.accData == ($past(rf.accData) | $past(rf.rdData)))
		else $error("OR result wrong");

	a_add_wrap: assert property (
		execOp(add_accum_op) |=>
			rf.accData == DATA_W'($past(rf.accData) + $past(rf.rdData)))
		else $error("Add result wrong");

	a_store_copy: assert property (
		execOp(store_accum_op) |=>
			u_regs.regsQ[selPrev] == $past(rf.accData))
		else $error("Store did not copy accumulator");

	a_shift_fill: assert property (
		execOp(shift_left_op) |->
			rf.wrData[0] == ((sel == SHIFT_FILL_REG) && rf.srcMsb)
			&& rf.wrData[15:1] == rf.rdData[14:0])
		else $error("Shift fill wrong");

	a_halt_hold: assert property (
		haltReq [*2] |-> $stable(pcQ) && $stable(stateQ) && !rf.wrEn)
		else $error("Core advanced while halted");

	a_addr_low: assert property (
		run |=> progAddr == 12'($past(pcQ) + PC_STEP))
		else $error("Memory address not low PC bits");

endmodule

// >>> sim/scd_prog_mem.sv
`timescale 1ns/1ps
module scd_prog_mem
	import scd_pkg::*;
(
	input  wire logic               ref_clk,
	input  wire logic [MEM_AW-1:0]  progAddr,
	input  wire logic               progRdEn,
	output logic      [INSTR_W-1:0] progData
);
	// ------------------------------------------------------------
	// Program store, loaded by the bench, never written by the core
	// ------------------------------------------------------------
	logic [INSTR_W-1:0] memQ [1<<MEM_AW];
	logic [INSTR_W-1:0] lastQ = 8'h00;

	// Same-cycle read; idle bus shows the inverse of the last byte
	always_comb progData = progRdEn ? memQ[progAddr] : ~lastQ;

	// Remember the last byte handed out
	always_ff @(posedge ref_clk) begin
		if (progRdEn) begin
			lastQ <= memQ[progAddr];
		end
	end
endmodule

// >>> sim/tb.sv
`timescale 1ns/1ps
module tb;
	import scd_pkg::*;
	localparam logic [SEL_W-1:0] ACC = 4'ha;
	logic               ref_clk, rst_n, haltReq, progRdEn, haltAck, foreignOp, rdReq, pendQ;
	logic [INSTR_W-1:0] progData, foreignInstr, expInstr;
	logic [MEM_AW-1:0]  progAddr;
	logic [SEL_W-1:0]   dbgSel;
	logic [DATA_W-1:0]  dbgData;
	logic [DATA_W-1:0]  expQ[$];
	logic [DATA_W-1:0]  model[REG_COUNT];
	int                 miscompares, n_checks, cycles, nForeign, expForeign, len, runCycles;

	// ------------------------------------------------------------
	// Clock, design and memory
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	scd_core #(.ACC_IDX(ACC)) dut (
		.ref_clk(ref_clk), .rst_n(rst_n), .haltReq(haltReq), .progData(progData),
		.progAddr(progAddr), .progRdEn(progRdEn), .haltAck(haltAck),
		.foreignOp(foreignOp), .foreignInstr(foreignInstr), .dbgSel(dbgSel),
		.dbgData(dbgData)
	);

	scd_prog_mem mem (
		.ref_clk(ref_clk), .progAddr(progAddr), .progRdEn(progRdEn), .progData(progData)
	);

	// ------------------------------------------------------------
	// Checking
	// ------------------------------------------------------------
	task automatic check16(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("Checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Cycle count, timeout and readback request delay
	always @(posedge ref_clk) begin
		pendQ <= rdReq;
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			report_and_stop();
		end
	end

	// Register readback lands one cycle after the select
	always @(negedge ref_clk) begin
		if (foreignOp === 1'b1) nForeign++;
		if (pendQ === 1'b1) check16(dbgData, expQ.pop_front());
	end

	// ------------------------------------------------------------
	// Program builder and reference model
	// ------------------------------------------------------------
	task automatic put(input logic [7:0] b);
		mem.memQ[len] = b;
		len++;
	endtask

	task automatic op(input logic [3:0] code, input logic [3:0] sel, input logic [15:0] orMask);
		logic [DATA_W-1:0] v;
		v = 16'($urandom) | orMask;
		put({code, sel});
		runCycles++;
		case (code)
			4'h0: begin
				put(v[15:8]);
				put(v[7:0]);
				model[sel] = v;
				runCycles += 2;
			end
			4'h1: model[sel] = CLEAR_VALUE;
			4'h2: model[ACC] = model[ACC] & model[sel];
			4'h3: model[ACC] = model[ACC] | model[sel];
			4'h4: model[ACC] = model[ACC] + model[sel];
			4'h5: model[sel] = model[ACC];
			4'h6: model[sel] = {model[sel][14:0],
				(sel == SHIFT_FILL_REG) ? model[SHIFT_SRC_REG][15] : 1'b0};
			default: begin
				expForeign++;
				expInstr = {code, sel};
			end
		endcase
	endtask

	task automatic readReg(input logic [SEL_W-1:0] s, input logic [DATA_W-1:0] e);
		@(posedge ref_clk);
		#1;
		dbgSel = s;
		rdReq = 1'b1;
		expQ.push_back(e);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		haltReq = 1'b1;
		dbgSel = 4'h0;
		rdReq = 1'b0;
		expInstr = 8'h00;
		void'($urandom(94));
		for (int a = 0; a < 4096; a++) mem.memQ[a] = 8'h70;
		foreach (model[i]) model[i] = REG_RESET;
		// Loads into every register, then a random mix, then the shift fill cases
		for (int r = 0; r < 16; r++) op(4'h0, 4'(r), 16'h0000);
		for (int i = 0; i < 80; i++) op(4'($urandom_range(1, 8)), 4'($urandom), 16'h0000);
		op(4'h0, SHIFT_SRC_REG, 16'h8000);
		op(4'h6, SHIFT_FILL_REG, 16'h0000);
		op(4'h6, SHIFT_SRC_REG, 16'h0000);
		op(4'h6, 4'h3, 16'h0000);

		// Reset, then run with a stall inside the second load
		repeat (12) @(posedge ref_clk);
		#1;
		rst_n = 1'b1;
		@(posedge ref_clk);
		#1;
		haltReq = 1'b0;
		repeat (5) @(posedge ref_clk);
		#1;
		haltReq = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		check16(16'(progAddr), 16'h0005);
		check16(16'({progRdEn, haltAck}), 16'h0001);
		haltReq = 1'b0;
		repeat (runCycles - 5) @(posedge ref_clk);
		#1;
		haltReq = 1'b1;
		@(posedge ref_clk);
		#1;
		check16(16'(progAddr), 16'(len));
		check16(16'(nForeign), 16'(expForeign));
		check16(16'(foreignInstr), 16'(expInstr));
		$display("Test program run done");

		// Read back all sixteen registers while halted
		for (int r = 0; r < 16; r++) readReg(4'(r), model[r]);
		@(posedge ref_clk);
		#1;
		rdReq = 1'b0;
		repeat (3) @(posedge ref_clk);
		$display("Test register readback done");

		// A full sweep of the space wraps back to the same address
		#1;
		haltReq = 1'b0;
		repeat (4096) @(posedge ref_clk);
		#1;
		haltReq = 1'b1;
		@(posedge ref_clk);
		#1;
		check16(16'(progAddr), 16'(len));
		$display("Test address wrap done");
		report_and_stop();
	end
endmodule
